// file: pfb_map.svh
`ifndef PFB_MAP_SVH
`define PFB_MAP_SVH

`define PFB_OFF_FLAGS_A 32'h0000_0000
`define PFB_OFF_FLAGS_B 32'h0000_0004
`define PFB_OFF_EN_A 32'h0000_0008
`define PFB_OFF_EN_B 32'h0000_000C
`define PFB_OFF_CTRL 32'h0000_0010
`define PFB_OFF_PRIO_A 32'h0000_0014
`define PFB_OFF_PRIO_B 32'h0000_0018
`define PFB_OFF_STATUS 32'h0000_001C

`define PFB_RST_FLAGS 8'h00
`define PFB_RST_EN 8'h00
`define PFB_RST_CTRL 8'h00
`define PFB_RST_PRIO 8'hFF

`define PFB_SW_MASK_A 8'hCF
`define PFB_SW_MASK_A28 8'h4F
`define PFB_EN_MASK_A28 8'h7F

`define PFB_BIT_PAR_PORT 7
`define PFB_BIT_SER_RX 5
`define PFB_BIT_SER_TX 4
`define PFB_BIT_GLOBAL_EN 7
`define PFB_BIT_PERIPH_EN 6
`define PFB_BIT_PRIO_EN 5
`define PFB_BIT_VOLT_DIR 0

`define PFB_RESP_OKAY 2'h0
`define PFB_RESP_SLVERR 2'h2

`endif

// file: pfb_pkg.sv
package pfb_pkg;

  typedef enum logic [1:0] {
    CCP_OFF = 2'b00,
    CCP_CAPTURE = 2'b01,
    CCP_COMPARE = 2'b10,
    CCP_PWM = 2'b11
  } pfb_ccp_mode_t;

  typedef struct packed {
    logic par_port_access;
    logic conv_done;
    logic ser_rx_full;
    logic ser_tx_empty;
    logic sync_ser_done;
    pfb_ccp_mode_t capcmp_one_mode;
    logic capcmp_one_capture;
    logic capcmp_one_match;
    logic timer_two_match;
    logic timer_one_ovf;
    logic osc_fail;
    logic clk_on_internal_hf;
    logic comp_one_out;
    logic comp_two_out;
    logic nvm_write_done;
    logic bus_collision;
    logic volt_above;
    logic timer_three_ovf;
    pfb_ccp_mode_t capcmp_two_mode;
    logic capcmp_two_capture;
    logic capcmp_two_match;
  } pfb_events_t;

endpackage

// file: pfb_bank.sv
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "pfb_map.svh"

module pfb_bank #(
  parameter bit PIN28 = 1'b0
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic [31:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire pfb_pkg::pfb_events_t EVT,
  output logic IRQ_HIGH,
  output logic IRQ_LOW
);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // capture or compare hit, never in pwm mode
  function automatic logic ccp_hit(input pfb_pkg::pfb_ccp_mode_t mode,
                                   input logic cap, input logic match);
    ccp_hit = (mode == pfb_pkg::CCP_CAPTURE && cap) ||
              (mode == pfb_pkg::CCP_COMPARE && match);
  endfunction

  function automatic logic is_mapped(input logic [31:0] addr);
    is_mapped = addr == `PFB_OFF_FLAGS_A || addr == `PFB_OFF_FLAGS_B ||
                addr == `PFB_OFF_EN_A || addr == `PFB_OFF_EN_B ||
                addr == `PFB_OFF_CTRL || addr == `PFB_OFF_PRIO_A ||
                addr == `PFB_OFF_PRIO_B || addr == `PFB_OFF_STATUS;
  endfunction

  logic [7:0] flags_a_q, flags_a_d;
  logic [7:0] flags_b_q, flags_b_d;
  logic [7:0] en_a_q;
  logic [7:0] en_b_q;
  logic [7:0] ctrl_q;
  logic [7:0] prio_a_q;
  logic [7:0] prio_b_q;
  logic aw_have_q;
  logic [31:0] awaddr_q;
  logic w_have_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic comp_one_prev_q;
  logic comp_two_prev_q;
  logic volt_prev_q;
  logic prime_q;
  logic irq_high_q;
  logic irq_low_q;
  logic wr_fire;
  logic wr_en;
  logic wr_flags_a, wr_flags_b, wr_en_a, wr_en_b;
  logic wr_ctrl, wr_prio_a, wr_prio_b;
  logic [7:0] set_a, set_b;
  logic [7:0] sw_mask_a;
  logic comp_one_chg, comp_two_chg, volt_evt;
  logic [15:0] pending, prio_bits;
  logic [31:0] rd_word;

  // write channel: address and data taken in either order
  assign S_AXI_AWREADY = CE & ~aw_have_q & ~bvalid_q;
  assign S_AXI_WREADY = CE & ~w_have_q & ~bvalid_q;
  assign S_AXI_BVALID = bvalid_q;
  assign S_AXI_BRESP = bresp_q;
  assign wr_fire = CE & aw_have_q & w_have_q;
  assign wr_en = wr_fire & wstrb_q[0];
  assign wr_flags_a = wr_en && awaddr_q == `PFB_OFF_FLAGS_A;
  assign wr_flags_b = wr_en && awaddr_q == `PFB_OFF_FLAGS_B;
  assign wr_en_a = wr_en && awaddr_q == `PFB_OFF_EN_A;
  assign wr_en_b = wr_en && awaddr_q == `PFB_OFF_EN_B;
  assign wr_ctrl = wr_en && awaddr_q == `PFB_OFF_CTRL;
  assign wr_prio_a = wr_en && awaddr_q == `PFB_OFF_PRIO_A;
  assign wr_prio_b = wr_en && awaddr_q == `PFB_OFF_PRIO_B;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      w_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `PFB_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        awaddr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(awaddr_q) ? `PFB_RESP_OKAY : `PFB_RESP_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read channel: one read at a time
  assign S_AXI_ARREADY = CE & ~rvalid_q;
  assign S_AXI_RVALID = rvalid_q;
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (S_AXI_ARADDR)
      `PFB_OFF_FLAGS_A: rd_word = {24'h00_0000, flags_a_q};
      `PFB_OFF_FLAGS_B: rd_word = {24'h00_0000, flags_b_q};
      `PFB_OFF_EN_A: rd_word = {24'h00_0000, en_a_q};
      `PFB_OFF_EN_B: rd_word = {24'h00_0000, en_b_q};
      `PFB_OFF_CTRL: rd_word = {24'h00_0000, ctrl_q};
      `PFB_OFF_PRIO_A: rd_word = {24'h00_0000, prio_a_q};
      `PFB_OFF_PRIO_B: rd_word = {24'h00_0000, prio_b_q};
      `PFB_OFF_STATUS: rd_word = {30'h0000_0000, irq_low_q, irq_high_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `PFB_RESP_OKAY;
    end else if (CE) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_word;
        rresp_q <= is_mapped(S_AXI_ARADDR) ? `PFB_RESP_OKAY
                                           : `PFB_RESP_SLVERR;
      end else if (rvalid_q && S_AXI_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // level history for change and edge detection
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      comp_one_prev_q <= 1'b0;
      comp_two_prev_q <= 1'b0;
      volt_prev_q <= 1'b0;
      prime_q <= 1'b0;
    end else if (CE) begin
      comp_one_prev_q <= EVT.comp_one_out;
      comp_two_prev_q <= EVT.comp_two_out;
      volt_prev_q <= EVT.volt_above;
      prime_q <= 1'b1;
    end
  end

  assign comp_one_chg = prime_q & (EVT.comp_one_out ^ comp_one_prev_q);
  assign comp_two_chg = prime_q & (EVT.comp_two_out ^ comp_two_prev_q);
  assign volt_evt = prime_q & (ctrl_q[`PFB_BIT_VOLT_DIR] ?
                    (EVT.volt_above & ~volt_prev_q) :
                    (~EVT.volt_above & volt_prev_q));

  // set terms, independent of enables
  assign set_a = {EVT.par_port_access & ~PIN28,
                  EVT.conv_done,
                  2'b00,
                  EVT.sync_ser_done,
                  ccp_hit(EVT.capcmp_one_mode, EVT.capcmp_one_capture,
                          EVT.capcmp_one_match),
                  EVT.timer_two_match,
                  EVT.timer_one_ovf};
  assign set_b = {EVT.osc_fail & EVT.clk_on_internal_hf,
                  comp_one_chg,
                  comp_two_chg,
                  EVT.nvm_write_done,
                  EVT.bus_collision,
                  volt_evt,
                  EVT.timer_three_ovf,
                  ccp_hit(EVT.capcmp_two_mode, EVT.capcmp_two_capture,
                          EVT.capcmp_two_match)};

  assign sw_mask_a = PIN28 ? `PFB_SW_MASK_A28 : `PFB_SW_MASK_A;

  // flags: software write, then hardware set on top; receive and transmit bits of A follow their levels
  always_comb begin
    flags_a_d = ((wr_flags_a ? wdata_q[7:0] : flags_a_q) & sw_mask_a)
                | set_a;
    flags_a_d[`PFB_BIT_SER_RX] = EVT.ser_rx_full;
    flags_a_d[`PFB_BIT_SER_TX] = EVT.ser_tx_empty;
    flags_b_d = (wr_flags_b ? wdata_q[7:0] : flags_b_q) | set_b;
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_a_q <= `PFB_RST_FLAGS;
      flags_b_q <= `PFB_RST_FLAGS;
    end else if (CE) begin
      flags_a_q <= flags_a_d;
      flags_b_q <= flags_b_d;
    end
  end

  // enables, control and priority bits
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      en_a_q <= `PFB_RST_EN;
      en_b_q <= `PFB_RST_EN;
    end else if (CE) begin
      if (wr_en_a) begin
        en_a_q <= PIN28 ? (wdata_q[7:0] & `PFB_EN_MASK_A28)
                        : wdata_q[7:0];
      end
      if (wr_en_b) begin
        en_b_q <= wdata_q[7:0];
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= `PFB_RST_CTRL;
      prio_a_q <= `PFB_RST_PRIO;
      prio_b_q <= `PFB_RST_PRIO;
    end else if (CE) begin
      if (wr_ctrl) begin
        ctrl_q <= wdata_q[7:0];
      end
      if (wr_prio_a) begin
        prio_a_q <= wdata_q[7:0];
      end
      if (wr_prio_b) begin
        prio_b_q <= wdata_q[7:0];
      end
    end
  end

  // request outputs
  assign pending = {flags_b_q & en_b_q, flags_a_q & en_a_q};
  assign prio_bits = {prio_b_q, prio_a_q};

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_high_q <= 1'b0;
      irq_low_q <= 1'b0;
    end else if (CE) begin
      if (ctrl_q[`PFB_BIT_PRIO_EN]) begin
        irq_high_q <= ctrl_q[`PFB_BIT_GLOBAL_EN] &
                      (|(pending & prio_bits));
        irq_low_q <= ctrl_q[`PFB_BIT_GLOBAL_EN] &
                     ctrl_q[`PFB_BIT_PERIPH_EN] &
                     (|(pending & ~prio_bits));
      end else begin
        irq_high_q <= ctrl_q[`PFB_BIT_GLOBAL_EN] &
                      ctrl_q[`PFB_BIT_PERIPH_EN] & (|pending);
        irq_low_q <= 1'b0;
      end
    end
  end

  assign IRQ_HIGH = irq_high_q;
  assign IRQ_LOW = irq_low_q;

  a_flag_no_enable: assert property (
    CE && EVT.timer_one_ovf && en_a_q[0] == 1'b0 |=> flags_a_q[0])
    else $error("timer one flag not set while disabled");

  a_rx_follows: assert property (
    CE |=> flags_a_q[5] == $past(EVT.ser_rx_full))
    else $error("receive flag does not follow buffer");

  a_tx_follows: assert property (
    CE |=> flags_a_q[4] == $past(EVT.ser_tx_empty))
    else $error("transmit flag does not follow buffer");

  a_sticky_hold: assert property (
    flags_b_q[4] && !wr_flags_b |=> flags_b_q[4])
    else $error("nonvolatile flag dropped without a write");

  a_set_wins: assert property (
    CE && wr_flags_a && EVT.timer_two_match |=> flags_a_q[1])
    else $error("set lost against software clear");

  a_comp_change: assert property (
    CE && prime_q && EVT.comp_one_out != comp_one_prev_q |=> flags_b_q[6])
    else $error("comparator change not flagged");

  a_capture_sets: assert property (
    CE && EVT.capcmp_two_mode == pfb_pkg::CCP_CAPTURE &&
    EVT.capcmp_two_capture |=> flags_b_q[0])
    else $error("capture did not set flag");

  a_par_port_zero: assert property (
    PIN28 |-> !flags_a_q[7] && !en_a_q[7])
    else $error("parallel port bits set on small variant");

  a_periph_gate: assert property (
    CE && !ctrl_q[5] && !ctrl_q[6] |=> !IRQ_HIGH && !IRQ_LOW)
    else $error("request without peripheral global enable");

  a_request_up: assert property (
    CE && !ctrl_q[5] && ctrl_q[7] && ctrl_q[6] &&
    (|(flags_a_q & en_a_q)) |=> IRQ_HIGH)
    else $error("enabled pending flag gave no request");

  a_low_prio: assert property (
    CE && ctrl_q[5] && ctrl_q[7] && ctrl_q[6] &&
    (|(pending & ~prio_bits)) |=> IRQ_LOW)
    else $error("low priority request missing");

  a_high_prio: assert property (
    CE && ctrl_q[5] && ctrl_q[7] && (|(pending & prio_bits)) |=> IRQ_HIGH)
    else $error("high priority request missing");

  a_volt_rise: assert property (
    CE && prime_q && ctrl_q[0] && EVT.volt_above && !volt_prev_q
    |=> flags_b_q[2])
    else $error("rising voltage event not flagged");

  a_comp_two_change: assert property (
    CE && prime_q && EVT.comp_two_out != comp_two_prev_q |=> flags_b_q[5])
    else $error("second comparator change not flagged");

  a_compare_sets: assert property (
    CE && EVT.capcmp_one_mode == pfb_pkg::CCP_COMPARE &&
    EVT.capcmp_one_match |=> flags_a_q[2])
    else $error("compare match did not set flag");

endmodule // pfb_bank

// file: pfb_periph_model.sv
`timescale 1ns/1ps
module pfb_periph_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire pfb_pkg::pfb_events_t req,
  output pfb_pkg::pfb_events_t evt
);
  // peripherals present a requested condition one clock later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
    end else begin
      evt <= req;
    end
  end
endmodule // pfb_periph_model

// file: tb_top.sv
`timescale 1ns/1ps
`include "pfb_map.svh"
module tb_top;
  logic clk, rst_n, ce, awv, wv, arv, awr, wrdy, bv, arr, rv, irqh, irql;
  logic [31:0] awaddr, wdata, araddr, rdata, v, rdata28;
  logic [1:0] bresp, rresp;
  logic [31:0] ta [9];
  logic [7:0] td [9];
  logic [1:0] te [9];
  pfb_pkg::pfb_events_t req, base, evt, tmp;
  int miscompares, checked, seed, i;
  pfb_periph_model PEER (.clk(clk), .rst_n(rst_n), .req(req), .evt(evt));
  pfb_bank DUT (.CLK(clk), .RST_N(rst_n), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .EVT(evt),
    .IRQ_HIGH(irqh), .IRQ_LOW(irql));
  // small variant on the same bus, only its read data is looked at
  pfb_bank #(.PIN28(1'b1)) DUT28 (.CLK(clk), .RST_N(rst_n), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
    .S_AXI_WREADY(), .S_AXI_BRESP(), .S_AXI_BVALID(),
    .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(), .S_AXI_RDATA(rdata28), .S_AXI_RRESP(),
    .S_AXI_RVALID(), .S_AXI_RREADY(1'b1), .EVT(evt),
    .IRQ_HIGH(), .IRQ_LOW());
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // both halves offered together, each released at the edge it is taken
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic tka, tkw, b;
    int n;
    b = 1'b0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (n = 0; n < 64 && !b; n++) begin
      @(negedge clk);
      tka = awv & awr;
      tkw = wv & wrdy;
      b = bv;
      if (b) chk("bresp", {30'h0, bresp}, {30'h0, er});
      @(posedge clk);
      if (tka) awv <= 1'b0;
      if (tkw) wv <= 1'b0;
    end
    if (!b) chk("bvalid", 32'h0, 32'h1);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic tk, r;
    int n;
    logic [31:0] x;
    r = 1'b0;
    x = (a == `PFB_OFF_FLAGS_A || a == `PFB_OFF_EN_A) ? exp & 32'h7F : exp;
    araddr <= a;
    arv <= 1'b1;
    for (n = 0; n < 64 && !r; n++) begin
      @(negedge clk);
      tk = arv & arr;
      r = rv;
      if (r) chk("rdata", rdata, exp);
      if (r) chk("rresp", {30'h0, rresp}, {30'h0, er});
      if (r) chk("rdata28", rdata28, x);
      @(posedge clk);
      if (tk) arv <= 1'b0;
    end
    if (!r) chk("rvalid", 32'h0, 32'h1);
  endtask
  task fire(input pfb_pkg::pfb_events_t e);
    req <= e;
    @(posedge clk);
    req <= base;
    repeat (3) @(posedge clk);
  endtask
  function automatic pfb_pkg::pfb_events_t ev(input int k);
    pfb_pkg::pfb_events_t e;
    e = base;
    case (k)
      15: e.par_port_access = 1'b1;
      14: e.conv_done = 1'b1;
      11: e.sync_ser_done = 1'b1;
      10: e.capcmp_one_capture = 1'b1;
      9: e.timer_two_match = 1'b1;
      8: e.timer_one_ovf = 1'b1;
      7: e.osc_fail = 1'b1;
      6: e.comp_one_out = 1'b1;
      5: e.comp_two_out = 1'b1;
      4: e.nvm_write_done = 1'b1;
      3: e.bus_collision = 1'b1;
      2: e.volt_above = 1'b0;
      1: e.timer_three_ovf = 1'b1;
      default: e.capcmp_two_match = 1'b1;
    endcase
    return e;
  endfunction
  initial begin
    #1000000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    seed = 32'h8A422A1C;
    miscompares = 0;
    checked = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    awv = 1'b0;
    wv = 1'b0;
    arv = 1'b0;
    awaddr = 32'h0;
    wdata = 32'h0;
    araddr = 32'h0;
    base = '0;
    base.capcmp_one_mode = pfb_pkg::CCP_CAPTURE;
    base.capcmp_two_mode = pfb_pkg::CCP_COMPARE;
    base.clk_on_internal_hf = 1'b1;
    base.volt_above = 1'b1;
    req = base;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 4; i++) rd(4 * i, 32'h0, `PFB_RESP_OKAY);
    rd(`PFB_OFF_PRIO_A, 32'hFF, `PFB_RESP_OKAY);
    rd(32'h20, 32'h0, `PFB_RESP_SLVERR);
    wr(32'h20, 32'hFF, `PFB_RESP_SLVERR);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      wr(`PFB_OFF_EN_A, v, `PFB_RESP_OKAY);
      wr(`PFB_OFF_EN_B, v >> 8, `PFB_RESP_OKAY);
      rd(`PFB_OFF_EN_A, {24'h0, v[7:0]}, `PFB_RESP_OKAY);
      rd(`PFB_OFF_EN_B, {24'h0, v[15:8]}, `PFB_RESP_OKAY);
    end
    wr(`PFB_OFF_EN_A, 32'h0, `PFB_RESP_OKAY);
    wr(`PFB_OFF_EN_B, 32'h0, `PFB_RESP_OKAY);
    // every sticky source with all enables off, then cleared by software
    for (i = 0; i < 16; i++) begin
      if (i != 12 && i != 13) begin
        fire(ev(i));
        v = (i < 8) ? `PFB_OFF_FLAGS_B : `PFB_OFF_FLAGS_A;
        rd(v, 32'h1 << (i % 8), `PFB_RESP_OKAY);
        wr(v, 32'h0, `PFB_RESP_OKAY);
        rd(v, 32'h0, `PFB_RESP_OKAY);
      end
    end
    base.capcmp_one_mode = pfb_pkg::CCP_PWM;
    base.capcmp_one_match = 1'b1;
    fire(ev(10));
    rd(`PFB_OFF_FLAGS_A, 32'h0, `PFB_RESP_OKAY);
    // compare on unit one, capture on unit two
    base.capcmp_one_match = 1'b0;
    base.capcmp_one_mode = pfb_pkg::CCP_COMPARE;
    base.capcmp_two_mode = pfb_pkg::CCP_CAPTURE;
    tmp = base;
    tmp.capcmp_one_match = 1'b1;
    tmp.capcmp_two_capture = 1'b1;
    fire(tmp);
    rd(`PFB_OFF_FLAGS_A, 32'h4, `PFB_RESP_OKAY);
    rd(`PFB_OFF_FLAGS_B, 32'h1, `PFB_RESP_OKAY);
    wr(`PFB_OFF_FLAGS_A, 32'h0, `PFB_RESP_OKAY);
    wr(`PFB_OFF_FLAGS_B, 32'h0, `PFB_RESP_OKAY);
    // rising direction: a fall is ignored, a rise is flagged
    wr(`PFB_OFF_CTRL, 32'h1, `PFB_RESP_OKAY);
    base.volt_above = 1'b0;
    fire(base);
    rd(`PFB_OFF_FLAGS_B, 32'h0, `PFB_RESP_OKAY);
    tmp = base;
    tmp.volt_above = 1'b1;
    fire(tmp);
    rd(`PFB_OFF_FLAGS_B, 32'h4, `PFB_RESP_OKAY);
    wr(`PFB_OFF_FLAGS_B, 32'h0, `PFB_RESP_OKAY);
    wr(`PFB_OFF_CTRL, 32'h0, `PFB_RESP_OKAY);
    base.ser_rx_full = 1'b1;
    base.ser_tx_empty = 1'b1;
    fire(base);
    wr(`PFB_OFF_FLAGS_A, 32'h0, `PFB_RESP_OKAY);
    rd(`PFB_OFF_FLAGS_A, 32'h30, `PFB_RESP_OKAY);
    base.ser_rx_full = 1'b0;
    base.ser_tx_empty = 1'b0;
    fire(base);
    wr(`PFB_OFF_FLAGS_A, 32'hFF, `PFB_RESP_OKAY);
    rd(`PFB_OFF_FLAGS_A, 32'hCF, `PFB_RESP_OKAY);
    wr(`PFB_OFF_FLAGS_A, 32'h0, `PFB_RESP_OKAY);
    // clear written while the match event stands
    base.timer_two_match = 1'b1;
    req <= base;
    wr(`PFB_OFF_FLAGS_A, 32'h0, `PFB_RESP_OKAY);
    base.timer_two_match = 1'b0;
    fire(base);
    rd(`PFB_OFF_FLAGS_A, 32'h2, `PFB_RESP_OKAY);
    wr(`PFB_OFF_FLAGS_A, 32'h0, `PFB_RESP_OKAY);
    fire(ev(8));
    ta = '{`PFB_OFF_EN_A, `PFB_OFF_CTRL, `PFB_OFF_CTRL, `PFB_OFF_PRIO_A,
      `PFB_OFF_CTRL, `PFB_OFF_CTRL, `PFB_OFF_CTRL, `PFB_OFF_PRIO_A,
      `PFB_OFF_EN_A};
    td = '{8'h01, 8'hC0, 8'h80, 8'h00, 8'hC0, 8'hE0, 8'hA0, 8'hFF, 8'h00};
    te = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0};
    for (i = 0; i < 9; i++) begin
      wr(ta[i], {24'h0, td[i]}, `PFB_RESP_OKAY);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("irq", {30'h0, irql, irqh}, {30'h0, te[i]});
      @(posedge clk);
      rd(`PFB_OFF_STATUS, {30'h0, te[i]}, `PFB_RESP_OKAY);
    end
    // reset in mid run brings flags and enables back to zero
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 4; i++) rd(4 * i, 32'h0, `PFB_RESP_OKAY);
    report_and_stop();
  end
endmodule // tb_top
